// *** src/exec_pkg.sv ***
// shared types and constants of the instruction execute datapath
package exec_pkg;

   // instructions accepted at the issue port
   typedef enum logic [4:0] {
      OP_BCD_ADJUST              = 5'h00,
      OP_SUBTRACT_ONE_MEM        = 5'h01,
      OP_SUBTRACT_ONE_TO_ACC     = 5'h02,
      OP_ADD_ONE_MEM             = 5'h03,
      OP_ADD_ONE_TO_ACC          = 5'h04,
      OP_POWER_DOWN              = 5'h05,
      OP_JUMP_ABSOLUTE           = 5'h06,
      OP_COPY_MEM_TO_ACC         = 5'h07,
      OP_COPY_IMM_TO_ACC         = 5'h08,
      OP_COPY_ACC_TO_MEM         = 5'h09,
      OP_IDLE_INSTRUCTION        = 5'h0A,
      OP_OR_MEM_TO_ACC           = 5'h0B,
      OP_OR_IMM_TO_ACC           = 5'h0C,
      OP_OR_TO_MEM               = 5'h0D,
      OP_SUBROUTINE_EXIT         = 5'h0E,
      OP_SUBROUTINE_EXIT_IMM     = 5'h0F,
      OP_INTERRUPT_EXIT          = 5'h10,
      OP_ROTATE_LEFT             = 5'h11,
      OP_ROTATE_LEFT_TO_ACC      = 5'h12,
      OP_ROTATE_LEFT_THRU_CARRY  = 5'h13,
      OP_ROTATE_LEFT_CARRY_ACC   = 5'h14,
      OP_ROTATE_RIGHT            = 5'h15,
      OP_ROTATE_RIGHT_TO_ACC     = 5'h16,
      OP_ROTATE_RIGHT_THRU_CARRY = 5'h17,
      OP_ROTATE_RIGHT_CARRY_ACC  = 5'h18,
      OP_SUBTRACT_WITH_BORROW    = 5'h19
   } op_t;

   // sequencer states, gray along idle, execute, dummy
   typedef enum logic [1:0] {
      S_IDLE  = 2'h0,
      S_EXEC  = 2'h1,
      S_DUMMY = 2'h3,
      S_HALT  = 2'h2
   } state_t;

   localparam int          PC_W           = 16;
   localparam logic [3:0]  BCD_NIBBLE_MAX = 4'h9;
   localparam logic [3:0]  BCD_FIX        = 4'h6;
   localparam logic [7:0]  ACC_RST        = 8'h00;
   localparam logic        FLAG_RST       = 1'b0;
   localparam logic        GIE_RST        = 1'b0;
   localparam logic [15:0] PC_RST         = 16'h0000;
   localparam logic [15:0] PC_STEP        = 16'h0001;
   localparam logic [7:0]  BYTE_ONE       = 8'h01;

endpackage

// *** src/mem_if.sv ***
// data memory access bundle between sequencer and memory
`timescale 1ns/1ps
interface mem_if #(parameter int AW = 8);
   logic          wr;
   logic [AW-1:0] addr;
   logic [7:0]    wdata;
   logic [7:0]    rdata;
   modport ctrl (output wr, output addr, output wdata, input rdata);
   modport mem  (input wr, input addr, input wdata, output rdata);
endinterface

// *** src/data_mem.sv ***
// byte wide data memory with registered read
`timescale 1ns/1ps
module data_mem #(
   parameter int AW = 8
) (
   input wire logic mclk,
   mem_if.mem       port
);
   logic [7:0] store [0:(1<<AW)-1];
   logic [7:0] rdata_r;

   // contents are retained, never reset; read-before-write
   always_ff @(posedge mclk) begin
      if (port.wr) begin
         store[port.addr] <= port.wdata;
      end
      rdata_r <= store[port.addr];
   end

   assign port.rdata = rdata_r;
endmodule

// *** src/exec_alu.sv ***
// combinational result and flag logic of the execute stage
`timescale 1ns/1ps
module exec_alu
   import exec_pkg::*;
(
   input  wire op_t        op,
   input  wire logic [7:0] acc,
   input  wire logic [7:0] mem,
   input  wire logic [7:0] imm,
   input  wire logic       cIn,
   input  wire logic       acIn,
   input  wire logic       zIn,
   output logic [7:0]      res,
   output logic            wrAcc,
   output logic            wrMem,
   output logic            updC,
   output logic            updZ,
   output logic            updArith,
   output logic            cOut,
   output logic            acOut,
   output logic            zOut,
   output logic            ovOut,
   output logic            scOut,
   output logic            czOut
);
   // bcd correction terms
   wire       loFix   = (acc[3:0] > BCD_NIBBLE_MAX) || acIn;
   wire       hiFix   = (acc[7:4] > BCD_NIBBLE_MAX) || cIn;
   wire [7:0] corr    = {hiFix ? BCD_FIX : 4'h0, loFix ? BCD_FIX : 4'h0};
   wire [8:0] bcdSum  = {1'b0, acc} + {1'b0, corr};
   // subtract with borrow, borrow is the inverted carry
   wire [8:0] diff    = {1'b0, acc} - {1'b0, mem} - {8'h00, ~cIn};
   wire [4:0] loDiff  = {1'b0, acc[3:0]} - {1'b0, mem[3:0]} - {4'h0, ~cIn};
   wire       sbcOv   = (acc[7] ^ mem[7]) & (acc[7] ^ diff[7]);
   // other operand paths
   wire [7:0] incVal  = mem + BYTE_ONE;
   wire [7:0] decVal  = mem - BYTE_ONE;
   wire [7:0] rotL    = {mem[6:0], mem[7]};
   wire [7:0] rotLc   = {mem[6:0], cIn};
   wire [7:0] rotR    = {mem[0], mem[7:1]};
   wire [7:0] rotRc   = {cIn, mem[7:1]};

   // fixed flag results
   assign zOut  = (res == 8'h00);
   assign acOut = ~loDiff[4];
   assign ovOut = sbcOv;
   assign scOut = sbcOv ^ diff[7];
   assign czOut = (diff[7:0] == 8'h00) & zIn;

   // per instruction result, destination and flag update
   always_comb begin
      res      = acc;
      wrAcc    = 1'b0;
      wrMem    = 1'b0;
      updC     = 1'b0;
      updZ     = 1'b0;
      updArith = 1'b0;
      cOut     = cIn;
      unique case (op)
         OP_BCD_ADJUST: begin
            res   = bcdSum[7:0];
            wrMem = 1'b1;
            updC  = 1'b1;
            cOut  = hiFix | bcdSum[8];
         end
         OP_SUBTRACT_ONE_MEM: begin
            res   = decVal;
            wrMem = 1'b1;
            updZ  = 1'b1;
         end
         OP_SUBTRACT_ONE_TO_ACC: begin
            res   = decVal;
            wrAcc = 1'b1;
            updZ  = 1'b1;
         end
         OP_ADD_ONE_MEM: begin
            res   = incVal;
            wrMem = 1'b1;
            updZ  = 1'b1;
         end
         OP_ADD_ONE_TO_ACC: begin
            res   = incVal;
            wrAcc = 1'b1;
            updZ  = 1'b1;
         end
         OP_COPY_MEM_TO_ACC: begin
            res   = mem;
            wrAcc = 1'b1;
         end
         OP_COPY_IMM_TO_ACC, OP_SUBROUTINE_EXIT_IMM: begin
            res   = imm;
            wrAcc = 1'b1;
         end
         OP_COPY_ACC_TO_MEM: begin
            res   = acc;
            wrMem = 1'b1;
         end
         OP_OR_MEM_TO_ACC: begin
            res   = acc | mem;
            wrAcc = 1'b1;
            updZ  = 1'b1;
         end
         OP_OR_IMM_TO_ACC: begin
            res   = acc | imm;
            wrAcc = 1'b1;
            updZ  = 1'b1;
         end
         OP_OR_TO_MEM: begin
            res   = acc | mem;
            wrMem = 1'b1;
            updZ  = 1'b1;
         end
         OP_ROTATE_LEFT, OP_ROTATE_LEFT_TO_ACC: begin
            res   = rotL;
            wrMem = (op == OP_ROTATE_LEFT);
            wrAcc = (op == OP_ROTATE_LEFT_TO_ACC);
         end
         OP_ROTATE_LEFT_THRU_CARRY, OP_ROTATE_LEFT_CARRY_ACC: begin
            res   = rotLc;
            wrMem = (op == OP_ROTATE_LEFT_THRU_CARRY);
            wrAcc = (op == OP_ROTATE_LEFT_CARRY_ACC);
            updC  = 1'b1;
            cOut  = mem[7];
         end
         OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_TO_ACC: begin
            res   = rotR;
            wrMem = (op == OP_ROTATE_RIGHT);
            wrAcc = (op == OP_ROTATE_RIGHT_TO_ACC);
         end
         OP_ROTATE_RIGHT_THRU_CARRY, OP_ROTATE_RIGHT_CARRY_ACC: begin
            res   = rotRc;
            wrMem = (op == OP_ROTATE_RIGHT_THRU_CARRY);
            wrAcc = (op == OP_ROTATE_RIGHT_CARRY_ACC);
            updC  = 1'b1;
            cOut  = mem[0];
         end
         OP_SUBTRACT_WITH_BORROW: begin
            res      = diff[7:0];
            wrAcc    = 1'b1;
            updC     = 1'b1;
            updZ     = 1'b1;
            updArith = 1'b1;
            cOut     = ~diff[8];
         end
         default: begin
            res = acc;                                    // no data effect: jump, plain and interrupt exits, power down, idle
         end
      endcase
   end
endmodule

// *** src/mcu_core_instruction_execute.sv ***
// execute sequencer, accumulator, status flags and program counter update
`timescale 1ns/1ps
// Contract
// - bcd adjust adds 6 to low nibble
// - bcd adjust adds 6 to high nibble
// - bcd result to memory, carry only
// - decrement to memory or acc, zero flag
// - increment to memory or acc, zero flag
// - power down stops, clears watchdog, retains data
// - power down sets pdf, clears timeout
// - jump loads pc, two cycles, no flags
// - copies move bytes, no flags
// - idle instruction only advances pc
// - or variants update zero only
// - subroutine exit pops pc, optional immediate
// - interrupt exit pops pc, sets enable
// - pending interrupt serviced before resuming
// - rotate left wraps bit 7
// - rotate left through carry
// - rotate right wraps bit 0
// - rotate right through carry
// - subtract with borrow and arithmetic flags
module mcu_core_instruction_execute
   import exec_pkg::*;
#(
   parameter int AW = 8
) (
   input  wire logic            mclk,
   input  wire logic            rst,
   input  wire logic            opValid,
   input  wire op_t             opCode,
   input  wire logic [AW-1:0]   opAddr,
   input  wire logic [7:0]      opImm,
   input  wire logic [PC_W-1:0] opTarget,
   input  wire logic [PC_W-1:0] stackTop,
   input  wire logic            intPending,
   input  wire logic            wakeEvent,
   input  wire logic            watchdogExpired,
   input  wire logic            loadWr,
   input  wire logic [AW-1:0]   loadAddr,
   input  wire logic [7:0]      loadData,
   output logic                 opReady,
   output logic                 opDone,
   output logic [7:0]           accOut,
   output logic                 carry,
   output logic                 halfCarry,
   output logic                 zero,
   output logic                 overflow,
   output logic                 signedCarry,
   output logic                 chainedZero,
   output logic                 powerDownFlag,
   output logic                 watchdogTimeoutFlag,
   output logic                 globalIntEnable,
   output logic [PC_W-1:0]      pcOut,
   output logic                 stackPop,
   output logic                 intService,
   output logic                 watchdogClear,
   output logic                 sysClockOff,
   output logic                 memWrStrobe,
   output logic [AW-1:0]        memWrAddr,
   output logic [7:0]           memWrData
);
   state_t            st_r, st_nxt;
   op_t               op_r;
   logic [AW-1:0]     addr_r;
   logic [7:0]        imm_r;
   logic [PC_W-1:0]   target_r;
   logic [7:0]        acc_r, acc_nxt;
   logic              c_r, ac_r, z_r, ov_r, sc_r, cz_r;
   logic              pdf_r, pdf_nxt, wto_r, wto_nxt, gie_r, gie_nxt;
   logic [PC_W-1:0]   pc_r, pc_nxt;
   logic              wrStb_r;
   logic [AW-1:0]     wrAddr_r;
   logic [7:0]        wrData_r;
   logic [7:0]        res;
   logic              wrAcc, wrMem, updC, updZ, updArith;
   logic              cOut, acOut, zOut, ovOut, scOut, czOut;

   mem_if #(.AW(AW)) dm ();

   data_mem #(.AW(AW)) u_mem (
      .mclk (mclk),
      .port (dm)
   );

   exec_alu u_alu (
      .op       (op_r),
      .acc      (acc_r),
      .mem      (dm.rdata),
      .imm      (imm_r),
      .cIn      (c_r),
      .acIn     (ac_r),
      .zIn      (z_r),
      .res      (res),
      .wrAcc    (wrAcc),
      .wrMem    (wrMem),
      .updC     (updC),
      .updZ     (updZ),
      .updArith (updArith),
      .cOut     (cOut),
      .acOut    (acOut),
      .zOut     (zOut),
      .ovOut    (ovOut),
      .scOut    (scOut),
      .czOut    (czOut)
   );

   // decode of sequencer conditions
   wire accept    = (st_r == S_IDLE) && opValid;
   wire loadTake  = (st_r == S_IDLE) && !opValid && loadWr;
   wire exe       = (st_r == S_EXEC);
   wire isJump    = (op_r == OP_JUMP_ABSOLUTE);
   wire isExit    = (op_r == OP_SUBROUTINE_EXIT) || (op_r == OP_SUBROUTINE_EXIT_IMM);
   wire isIntExit = (op_r == OP_INTERRUPT_EXIT);
   wire isHalt    = (op_r == OP_POWER_DOWN);
   wire twoCycle  = isJump || isExit || isIntExit;
   wire [PC_W-1:0] pcNext = pc_r + PC_STEP;                   // full width, wraps at the top

   // memory port: issue read on accept, write in execute
   assign dm.wr    = (exe && wrMem) || loadTake;
   assign dm.addr  = exe ? addr_r : (accept ? opAddr : loadAddr);
   assign dm.wdata = exe ? res : loadData;

   // next state
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         S_IDLE:  st_nxt = accept ? S_EXEC : S_IDLE;
         S_EXEC:  st_nxt = isHalt ? S_HALT : (twoCycle ? S_DUMMY : S_IDLE);
         S_DUMMY: st_nxt = S_IDLE;
         S_HALT:  st_nxt = wakeEvent ? S_IDLE : S_HALT;
      endcase
   end

   // accumulator, program counter, control flags
   assign acc_nxt = (exe && wrAcc) ? res : acc_r;
   assign pc_nxt  = !exe ? pc_r :
                    isJump ? target_r :
                    (isExit || isIntExit) ? stackTop :
                    isHalt ? pc_r : pcNext;
   assign gie_nxt = (exe && isIntExit) ? 1'b1 : gie_r;
   assign pdf_nxt = (exe && isHalt) ? 1'b1 : pdf_r;
   // a timeout in the same cycle as the clear wins
   assign wto_nxt = watchdogExpired ? 1'b1 : ((exe && isHalt) ? 1'b0 : wto_r);

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_r <= S_IDLE;
         pc_r <= PC_RST;
      end else begin
         st_r <= st_nxt;
         pc_r <= (st_r == S_HALT && wakeEvent) ? pcNext : pc_nxt;
      end
   end

   // capture of the issued instruction
   always_ff @(posedge mclk) begin
      if (rst) begin
         op_r     <= OP_IDLE_INSTRUCTION;
         addr_r   <= '0;
         imm_r    <= 8'h00;
         target_r <= PC_RST;
      end else if (accept) begin
         op_r     <= opCode;
         addr_r   <= opAddr;
         imm_r    <= opImm;
         target_r <= opTarget;
      end
   end

   // accumulator and status flags
   always_ff @(posedge mclk) begin
      if (rst) begin
         acc_r <= ACC_RST;
         c_r   <= FLAG_RST;
         z_r   <= FLAG_RST;
         ac_r  <= FLAG_RST;
         ov_r  <= FLAG_RST;
         sc_r  <= FLAG_RST;
         cz_r  <= FLAG_RST;
         pdf_r <= FLAG_RST;
         wto_r <= FLAG_RST;
         gie_r <= GIE_RST;
      end else begin
         acc_r <= acc_nxt;
         c_r   <= (exe && updC) ? cOut : c_r;
         z_r   <= (exe && updZ) ? zOut : z_r;
         ac_r  <= (exe && updArith) ? acOut : ac_r;
         ov_r  <= (exe && updArith) ? ovOut : ov_r;
         sc_r  <= (exe && updArith) ? scOut : sc_r;
         cz_r  <= (exe && updArith) ? czOut : cz_r;
         pdf_r <= pdf_nxt;
         wto_r <= wto_nxt;
         gie_r <= gie_nxt;
      end
   end

   // registered copy of each memory write for observation
   always_ff @(posedge mclk) begin
      if (rst) begin
         wrStb_r  <= 1'b0;
         wrAddr_r <= '0;
         wrData_r <= 8'h00;
      end else begin
         wrStb_r  <= dm.wr;
         wrAddr_r <= dm.addr;
         wrData_r <= dm.wdata;
      end
   end

   // output drive
   assign opReady             = (st_r == S_IDLE);
   assign opDone              = (exe && !twoCycle) || (st_r == S_DUMMY);
   assign stackPop            = exe && (isExit || isIntExit);
   assign intService          = (st_r == S_DUMMY) && isIntExit && intPending;
   assign watchdogClear       = exe && isHalt;
   assign sysClockOff         = (st_r == S_HALT);
   assign accOut              = acc_r;
   assign carry               = c_r;
   assign halfCarry           = ac_r;
   assign zero                = z_r;
   assign overflow            = ov_r;
   assign signedCarry         = sc_r;
   assign chainedZero         = cz_r;
   assign powerDownFlag       = pdf_r;
   assign watchdogTimeoutFlag = wto_r;
   assign globalIntEnable     = gie_r;
   assign pcOut               = pc_r;
   assign memWrStrobe         = wrStb_r;
   assign memWrAddr           = wrAddr_r;
   assign memWrData           = wrData_r;

   // checks on the execute behaviour
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   AST_BCD_LOW: assert property (
      (exe && op_r == OP_BCD_ADJUST && (acc_r[3:0] > BCD_NIBBLE_MAX || ac_r))
      |=> memWrStrobe && memWrData[3:0] == $past(acc_r[3:0]) + BCD_FIX)
      else $error("bcd low nibble not corrected");
   AST_BCD_KEEP: assert property (
      (exe && op_r == OP_BCD_ADJUST && acc_r[3:0] <= BCD_NIBBLE_MAX && !ac_r)
      |=> memWrData[3:0] == $past(acc_r[3:0]))
      else $error("bcd low nibble changed");
   AST_BCD_HIGH: assert property (
      (exe && op_r == OP_BCD_ADJUST && (acc_r[7:4] > BCD_NIBBLE_MAX || c_r)) |=> carry)
      else $error("bcd high correction lost carry");
   AST_BCD_FLAGS: assert property (
      (exe && op_r == OP_BCD_ADJUST) |=> acc_r == $past(acc_r) && zero == $past(z_r)
      && halfCarry == $past(ac_r))
      else $error("bcd adjust touched more than carry");
   AST_DEC_ACC: assert property (
      (exe && op_r == OP_SUBTRACT_ONE_TO_ACC) |=> accOut == $past(dm.rdata) - BYTE_ONE
      && !memWrStrobe && zero == (accOut == 8'h00))
      else $error("decrement to accumulator wrong");
   AST_INC_MEM: assert property (
      (exe && op_r == OP_ADD_ONE_MEM) |=> memWrStrobe && memWrData == $past(dm.rdata) + BYTE_ONE
      && zero == (memWrData == 8'h00) && carry == $past(c_r))
      else $error("increment to memory wrong");
   AST_HALT: assert property (
      (exe && isHalt) |-> watchdogClear ##1 sysClockOff && powerDownFlag
      && (watchdogTimeoutFlag == $past(watchdogExpired)))
      else $error("power down entry wrong");
   AST_HALT_FLAGS: assert property (
      (exe && isHalt) |=> carry == $past(c_r) && zero == $past(z_r) && acc_r == $past(acc_r))
      else $error("power down changed status");
   AST_JUMP: assert property (
      (exe && isJump) |=> (st_r == S_DUMMY && pcOut == $past(target_r) && opDone) ##1 opReady)
      else $error("jump sequence wrong");
   AST_COPY_IMM: assert property (
      (exe && op_r == OP_COPY_IMM_TO_ACC) |=> accOut == $past(imm_r) && zero == $past(z_r))
      else $error("copy immediate wrong");
   AST_IDLE_OP: assert property (
      (exe && op_r == OP_IDLE_INSTRUCTION) |=> accOut == $past(acc_r) && carry == $past(c_r)
      && pcOut == $past(pc_r) + PC_STEP && !memWrStrobe)
      else $error("idle instruction changed state");
   AST_OR_MEM: assert property (
      (exe && op_r == OP_OR_TO_MEM) |=> memWrData == ($past(acc_r) | $past(dm.rdata))
      && accOut == $past(acc_r))
      else $error("or to memory wrong");
   AST_EXIT_IMM: assert property (
      (exe && op_r == OP_SUBROUTINE_EXIT_IMM) |-> stackPop ##1 pcOut == $past(stackTop)
      && accOut == $past(imm_r))
      else $error("subroutine exit wrong");
   AST_INT_EXIT: assert property (
      (exe && isIntExit) |=> globalIntEnable && pcOut == $past(stackTop))
      else $error("interrupt exit wrong");
   AST_INT_SERVICE: assert property (
      (exe && isIntExit) ##1 intPending |-> intService)
      else $error("pending interrupt not serviced");
   AST_ROT_LEFT_ACC: assert property (
      (exe && op_r == OP_ROTATE_LEFT_TO_ACC) |=> accOut == {$past(dm.rdata[6:0]), $past(dm.rdata[7])}
      && !memWrStrobe)
      else $error("rotate left wrong");
   AST_ROT_LEFT_C: assert property (
      (exe && op_r == OP_ROTATE_LEFT_THRU_CARRY) |=> carry == $past(dm.rdata[7])
      && memWrData == {$past(dm.rdata[6:0]), $past(c_r)})
      else $error("rotate left through carry wrong");
   AST_ROT_RIGHT: assert property (
      (exe && op_r == OP_ROTATE_RIGHT) |=> memWrData == {$past(dm.rdata[0]), $past(dm.rdata[7:1])}
      && carry == $past(c_r))
      else $error("rotate right wrong");
   AST_ROT_RIGHT_C: assert property (
      (exe && op_r == OP_ROTATE_RIGHT_CARRY_ACC) |=> carry == $past(dm.rdata[0])
      && accOut == {$past(c_r), $past(dm.rdata[7:1])})
      else $error("rotate right through carry wrong");
   AST_SBC: assert property (
      (exe && op_r == OP_SUBTRACT_WITH_BORROW) |=> carry == ({1'b0, $past(acc_r)} >=
      ({1'b0, $past(dm.rdata)} + {8'h00, !$past(c_r)})) && zero == (accOut == 8'h00))
      else $error("subtract with borrow carry wrong");

   COV_BCD: cover property (exe && op_r == OP_BCD_ADJUST && c_r && ac_r);
   COV_HALT_WAKE: cover property (sysClockOff ##[1:20] opReady);
   COV_INT_SERVICE: cover property (intService);
   COV_SBC_BORROW: cover property (exe && op_r == OP_SUBTRACT_WITH_BORROW ##1 !carry);
endmodule

// *** verification/test_mcu_core_instruction_execute.sv ***
// self-checking bench of the execute datapath against a behavioural model
`timescale 1ns/1ps
module test_mcu_core_instruction_execute import exec_pkg::*;;
   logic       mclk = 1'b0, rst = 1'b1, opValid = 1'b0, wakeEvent = 1'b0, loadWr = 1'b0;
   op_t        opCode = OP_IDLE_INSTRUCTION;
   logic [7:0] opAddr = 8'h00, opImm = 8'h00, loadAddr = 8'h00, loadData = 8'h00, accOut, memWrAddr, memWrData;
   logic [15:0] opTarget = 16'h0000, stackTop = 16'h0000, pcOut;
   logic       opReady, opDone, carry, halfCarry, zero, overflow, signedCarry, chainedZero, memWrStrobe;
   logic       powerDownFlag, watchdogTimeoutFlag, globalIntEnable, sysClockOff;
   logic       intPending = 1'b0, watchdogExpired = 1'b0, stackPop, intService, watchdogClear;
   int         miscompares = 0, cmp_count = 0;
   int         acc, c, ac, z, ov, sc, cz, gie, power_down_flag, wto, pc, mem [256];

   mcu_core_instruction_execute #(.AW(8)) dut_u (.mclk, .rst, .opValid, .opCode, .opAddr, .opImm, .opTarget,
      .stackTop, .intPending, .wakeEvent, .watchdogExpired, .loadWr, .loadAddr, .loadData, .opReady,
      .opDone, .accOut, .carry, .halfCarry, .zero, .overflow, .signedCarry, .chainedZero, .powerDownFlag,
      .watchdogTimeoutFlag, .globalIntEnable, .pcOut, .stackPop, .intService, .watchdogClear, .sysClockOff,
      .memWrStrobe, .memWrAddr, .memWrData);

   // clock generation
   always #10 mclk = ~mclk;

   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic preload(logic [7:0] a, logic [7:0] d);
      loadWr = 1'b1; loadAddr = a; loadData = d; mem[a] = d;
      watchdogExpired = 1'($urandom); wto = wto | watchdogExpired;
      @(posedge mclk); #1 loadWr = 1'b0;
      watchdogExpired = 1'b0;
   endtask

   // model one instruction, issue it, compare every result
   task automatic run(op_t o, logic [7:0] a, logic [7:0] im, logic [15:0] tg);
      int m, r, w, n;
      m = mem[a]; w = -1; r = acc; pc = pc + 1;
      case (o)
         OP_BCD_ADJUST: begin
            r = acc + ((acc % 16 > 9 || ac) ? 6 : 0) + ((acc / 16 > 9 || c) ? 96 : 0);
            c = (acc / 16 > 9 || c || r > 255); w = r % 256; r = acc;
         end
         OP_SUBTRACT_ONE_MEM, OP_ADD_ONE_MEM: begin w = (m + (o == OP_ADD_ONE_MEM ? 1 : 255)) % 256; z = w == 0; end
         OP_SUBTRACT_ONE_TO_ACC, OP_ADD_ONE_TO_ACC: begin r = (m + (o == OP_ADD_ONE_TO_ACC ? 1 : 255)) % 256; z = r == 0; end
         OP_POWER_DOWN: begin power_down_flag = 1; wto = 0; pc = pc - 1; end
         OP_JUMP_ABSOLUTE: pc = tg;
         OP_COPY_MEM_TO_ACC: r = m;
         OP_COPY_IMM_TO_ACC: r = im;
         OP_COPY_ACC_TO_MEM: w = acc;
         OP_OR_MEM_TO_ACC, OP_OR_IMM_TO_ACC: begin r = acc | (o == OP_OR_IMM_TO_ACC ? im : m); z = r == 0; end
         OP_OR_TO_MEM: begin w = acc | m; z = w == 0; end
         OP_SUBROUTINE_EXIT: pc = tg;
         OP_SUBROUTINE_EXIT_IMM: begin pc = tg; r = im; end
         OP_INTERRUPT_EXIT: begin pc = tg; gie = 1; end
         OP_SUBTRACT_WITH_BORROW: begin
            r = acc - m - 1 + c; ac = acc % 16 - m % 16 - 1 + c >= 0;
            ov = ((acc ^ m) & (acc ^ r) & 128) != 0; c = r >= 0; r = r & 255;
            sc = ov ^ (r >= 128); cz = (r == 0) && z; z = r == 0;
         end
         default: if (o >= OP_ROTATE_LEFT && o <= OP_ROTATE_RIGHT_CARRY_ACC) begin
            n = o - OP_ROTATE_LEFT;
            r = n < 4 ? (m * 2 + (n > 1 ? c : m / 128)) % 256 : m / 2 + 128 * (n > 5 ? c : m % 2);
            if (n % 4 > 1) c = n < 4 ? m / 128 : m % 2;
            if (n % 2 == 0) begin w = r; r = acc; end
         end
      endcase
      acc = r;
      stackTop = tg; opTarget = tg; opCode = o; opAddr = a; opImm = im; opValid = 1'b1;
      intPending = 1'($urandom);
      @(posedge mclk); #1 opValid = 1'b0;
      chk("pulses", {stackPop, watchdogClear},
         {o inside {OP_SUBROUTINE_EXIT, OP_SUBROUTINE_EXIT_IMM, OP_INTERRUPT_EXIT}, o == OP_POWER_DOWN});
      for (n = 0; n < 4 && opDone !== 1'b1; n++) begin @(posedge mclk); #1; end
      chk("opDone", n < 4, 1);
      chk("intService", intService, o == OP_INTERRUPT_EXIT && intPending);
      @(posedge mclk); #1;
      chk("state", {accOut, carry, halfCarry, zero, overflow, signedCarry, chainedZero, globalIntEnable, powerDownFlag,
         watchdogTimeoutFlag}, {acc[7:0], c[0], ac[0], z[0], ov[0], sc[0], cz[0], gie[0], power_down_flag[0], wto[0]});
      chk("pc", pcOut, pc[15:0]);
      if (w >= 0) begin
         mem[a] = w;
         chk("memWr", {memWrStrobe, memWrAddr, memWrData}, {1'b1, a, w[7:0]});
      end
      if (o == OP_POWER_DOWN) begin
         chk("halt", {sysClockOff, opReady}, 2'b10);
         wakeEvent = 1'b1; pc++;
         @(posedge mclk); #1 wakeEvent = 1'b0;
      end
   endtask

   // hang guard
   initial begin
      #200000 miscompares++;
      give_verdict();
   end

   // reset, directed corner cases, every code once, then random traffic
   initial begin
      void'($urandom(17537));
      repeat (2) @(posedge mclk);
      #1 rst = 1'b0;
      for (int k = 0; k < 16; k++) preload(8'(k), 8'($urandom));
      preload(8'h20, 8'h00); run(OP_SUBTRACT_ONE_MEM, 8'h20, 8'h00, 16'h0000);
      preload(8'h21, 8'hFF); run(OP_ADD_ONE_TO_ACC, 8'h21, 8'h00, 16'h0000);
      run(OP_COPY_IMM_TO_ACC, 8'h00, 8'h99, 16'h0000); run(OP_BCD_ADJUST, 8'h22, 8'h00, 16'h0000);
      $display("test directed done");
      for (int k = 0; k < 26; k++) run(op_t'(5'(k)), 8'(k % 16), 8'($urandom), 16'($urandom));
      $display("test all codes done");
      repeat (300) begin
         if ($urandom_range(3) == 0) preload(8'($urandom_range(15)), 8'($urandom));
         run(op_t'(5'($urandom_range(25))), 8'($urandom_range(15)), 8'($urandom), 16'($urandom));
      end
      $display("test random done");
      give_verdict();
   end
endmodule
